/* File: src/ppm_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants for the port pin function mux
package ppm_pkg;
   // Port count and width
   localparam int PPM_PORTS = 10;
   localparam int PPM_PINS = 80;
   // Function select codes, two bits per pin
   localparam logic [1:0] PPM_FN_GPIN = 2'h0; // Input only, HiZ
   localparam logic [1:0] PPM_FN_ALT1 = 2'h1; // Output choice 1 (GP out)
   localparam logic [1:0] PPM_FN_ALT2 = 2'h2; // Output choice 2
   localparam logic [1:0] PPM_FN_ALT3 = 2'h3; // Output choice 3
   // Register byte addresses
   localparam logic [11:0] PPM_A_FSEL0 = 12'h000; // Pins 0..15 select
   localparam logic [11:0] PPM_A_FSEL4 = 12'h010; // Pins 64..79 select
   localparam logic [11:0] PPM_A_GPOUT0 = 12'h020; // Ports 0..3 GP out
   localparam logic [11:0] PPM_A_GPOUT1 = 12'h024; // Ports 4..7 GP out
   localparam logic [11:0] PPM_A_GPOUT2 = 12'h028; // Ports 8..9 GP out
   localparam logic [11:0] PPM_A_PIN0 = 12'h030; // Pin levels 0..31
   localparam logic [11:0] PPM_A_PIN1 = 12'h034; // Pin levels 32..63
   localparam logic [11:0] PPM_A_PIN2 = 12'h038; // Pin levels 64..79
   localparam logic [11:0] PPM_A_AIN0 = 12'h040; // Alt input enable lo
   localparam logic [11:0] PPM_A_AIN1 = 12'h044; // Alt input enable mid
   localparam logic [11:0] PPM_A_AIN2 = 12'h048; // Alt input enable hi
   localparam logic [11:0] PPM_A_POL = 12'h050; // Polarity select
   localparam logic [11:0] PPM_A_BUS = 12'h054; // Ext bus control
   // Ext bus control field positions
   localparam int PPM_BUS_EN = 0; // Bus owns its ports
   localparam int PPM_BUS_MODE = 1; // 0: 8-bit plain, 1: 16-bit muxed
   localparam int PPM_BUS_BSEL = 2; // Strobe balls as byte selects
   localparam int PPM_BUS_ALEPOL = 3; // Address latch strobe inverted
   // Polarity field positions
   localparam int PPM_POL_IRQ = 0;
   localparam int PPM_POL_CAP = 1;
   localparam int PPM_POL_CMP = 2;
   localparam int PPM_POL_TACH = 3;
   localparam int PPM_POL_ESTOP = 4;
   localparam int PPM_POL_PHASE = 5;
   // Reset values
   localparam logic [31:0] PPM_RST_ZERO = 32'h0000_0000;
   // Bus pin positions in the 80-bit flat pin vector
   localparam int PPM_P7_LSB = 56;
   localparam int PPM_P8_LSB = 64;
   localparam int PPM_P9_LSB = 72;
endpackage
`default_nettype wire

/* File: src/ppm_sync.sv */
`default_nettype none
// ==========================================================
// Two-stage synchroniser for pin levels
module ppm_sync #(
   parameter int WIDTH = 80
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // First stage, read only by the second
   logic [WIDTH-1:0] stage1;

   // Both stages clear on reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

/* File: src/ppm_polarity.sv */
`default_nettype none
// ==========================================================
// Polarity stage shared by input and output signals
module ppm_polarity #(
   parameter int WIDTH = 6
) (
   input wire logic [WIDTH-1:0] invert,
   input wire logic [WIDTH-1:0] from_pin,
   output logic [WIDTH-1:0] to_periph,
   input wire logic [WIDTH-1:0] from_periph,
   output logic [WIDTH-1:0] to_pin
);
   // Same inversion each way, so a round trip is neutral
   always_comb begin
      to_periph = from_pin ^ invert;
      to_pin = from_periph ^ invert;
   end
endmodule
`default_nettype wire

/* File: src/ppm_mux.sv */
`default_nettype none
// ==========================================================
// Port pin function mux with APB register access
// Notes on behaviour
// RL1 - Reset leaves ports 0-9 high impedance
// RL2 - Pin levels readable as GP input
// RL3 - Default peripheral inputs follow pins from reset
// RL4 - GP input readable even in alternate mode
// RL5 - One alt input, three alt outputs
// RL6 - 8-bit plain bus: data p8, address p7/p9
// RL7 - 16-bit muxed bus: p8/p9 AD, p7 high
// RL8 - Programmable polarity on listed signals
// RL9 - Write strobe balls switchable to byte selects
// RL10 - No pull resistor setting exists
// RL11 - Firmware may drive unused pins low
// RL12 - No phy clock without the network controller
// RL13 - Bus register picks strobe or byte select
// RL14 - Output select enables driver from peripheral
// RL15 - Polarity inverts both directions alike
module ppm_mux
   import ppm_pkg::*;
#(
   parameter bit HAS_ETH = 1'b1
) (
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port pins, flat vector port*8+bit
   input wire logic [ppm_pkg::PPM_PINS-1:0] pin_in,
   output logic [ppm_pkg::PPM_PINS-1:0] pin_out,
   output logic [ppm_pkg::PPM_PINS-1:0] pin_oe,
   // Peripheral output choices 2 and 3 per pin
   input wire logic [ppm_pkg::PPM_PINS-1:0] periph_out2,
   input wire logic [ppm_pkg::PPM_PINS-1:0] periph_out3,
   // Peripheral input views of pins
   output logic [ppm_pkg::PPM_PINS-1:0] default_in,
   output logic [ppm_pkg::PPM_PINS-1:0] alt_in,
   // Ext bus address/data from the bus controller
   input wire logic [23:0] ext_bus_addr,
   input wire logic [15:0] ext_bus_wdata,
   input wire logic ext_bus_addr_phase,
   input wire logic ext_bus_drive_data,
   output logic [15:0] ext_bus_rdata,
   // Strobe balls
   input wire logic ext_bus_wr_low,
   input wire logic ext_bus_wr_high,
   input wire logic ext_bus_byte_low,
   input wire logic ext_bus_byte_high,
   input wire logic ext_bus_latch,
   output logic ext_bus_low_write_strobe,
   output logic ext_bus_high_write_strobe,
   output logic ext_bus_address_latch_strobe,
   // Polarity-controlled signals
   input wire logic [3:0] irq_pin,
   output logic [3:0] irq_req,
   input wire logic [3:0] cap_pin,
   output logic [3:0] cap_in,
   input wire logic [3:0] cmp_periph,
   output logic [3:0] cmp_pin,
   input wire logic tach_pin,
   output logic tach_in,
   input wire logic estop_pin,
   output logic estop_in,
   input wire logic [5:0] phase_periph,
   output logic [5:0] phase_pin,
   // Phy reference clock request
   input wire logic phy_clk_src,
   output logic phy_reference_clock_out
);
   import ppm_pkg::*;

   // ==========================================================
   // Register state
   logic [159:0] fsel; // Two select bits per pin
   logic [159:0] next_fsel;
   logic [79:0] gpout; // GP output levels
   logic [79:0] next_gpout;
   logic [79:0] ain; // Alternate input enables
   logic [79:0] next_ain;
   logic [5:0] pol; // Polarity bits
   logic [5:0] next_pol;
   logic [3:0] busctl; // Ext bus control
   logic [3:0] next_busctl;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [79:0] pin_sync; // Synchronised pin levels

   // Field read helper for one 16-pin select word
   function automatic logic [31:0] fsel_word(input logic [159:0] f,
                                              input int idx);
      fsel_word = f[idx*32 +: 32];
   endfunction

   // ==========================================================
   // Pin synchroniser
   ppm_sync #(.WIDTH(PPM_PINS)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // ==========================================================
   // APB access decode
   // Zero wait states; unmapped addresses answer with pslverr
   always_comb begin
      logic acc;
      logic hit;
      logic wen;
      hit = 1'b1;
      // Commit only at the edge sampling pready
      wen = psel && penable && pready && pwrite;
      next_fsel = fsel;
      next_gpout = gpout;
      next_ain = ain;
      next_pol = pol;
      next_busctl = busctl;
      next_prdata = PPM_RST_ZERO;
      next_pslverr = 1'b0;
      acc = psel && !penable;
      next_pready = acc;
      if (psel) begin
         // Select words are only the five low addresses
         if (paddr <= PPM_A_FSEL4 && paddr[1:0] == 2'b00) begin
            next_prdata = fsel_word(fsel, int'(paddr[4:2]));
            if (wen)
               next_fsel[int'(paddr[4:2])*32 +: 32] = pwdata; // [RL5]
         end else begin
            unique case (paddr)
               PPM_A_GPOUT0: begin
                  next_prdata = gpout[31:0];
                  if (wen) next_gpout[31:0] = pwdata; // [RL11]
               end
               PPM_A_GPOUT1: begin
                  next_prdata = gpout[63:32];
                  if (wen) next_gpout[63:32] = pwdata;
               end
               PPM_A_GPOUT2: begin
                  next_prdata = {16'h0000, gpout[79:64]};
                  if (wen) next_gpout[79:64] = pwdata[15:0];
               end
               // Pin levels readable whatever the selection [RL2] [RL4]
               PPM_A_PIN0: next_prdata = pin_sync[31:0];
               PPM_A_PIN1: next_prdata = pin_sync[63:32];
               PPM_A_PIN2: next_prdata = {16'h0000, pin_sync[79:64]};
               PPM_A_AIN0: begin
                  next_prdata = ain[31:0];
                  if (wen) next_ain[31:0] = pwdata; // [RL5]
               end
               PPM_A_AIN1: begin
                  next_prdata = ain[63:32];
                  if (wen) next_ain[63:32] = pwdata;
               end
               PPM_A_AIN2: begin
                  next_prdata = {16'h0000, ain[79:64]};
                  if (wen) next_ain[79:64] = pwdata[15:0];
               end
               PPM_A_POL: begin
                  next_prdata = {26'h0, pol};
                  if (wen) next_pol = pwdata[5:0]; // [RL8]
               end
               PPM_A_BUS: begin
                  next_prdata = {28'h0, busctl};
                  if (wen) next_busctl = pwdata[3:0]; // [RL13]
               end
               default: hit = 1'b0;
            endcase
         end
         if (!hit) begin
            next_pslverr = acc;
            next_prdata = PPM_RST_ZERO;
         end
      end
   end

   // Registers; all selects zero so every pin is HiZ input [RL1]
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fsel <= '0;
         gpout <= '0;
         ain <= '0;
         pol <= '0;
         busctl <= '0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         fsel <= next_fsel;
         gpout <= next_gpout;
         ain <= next_ain;
         pol <= next_pol;
         busctl <= next_busctl;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ==========================================================
   // Polarity stages, one cell for each direction
   logic [13:0] pol_in_raw;
   logic [13:0] pol_in_cooked;
   logic [9:0] pol_out_raw;
   logic [9:0] pol_out_cooked;
   logic [13:0] inv_in;
   logic [9:0] inv_out;

   assign pol_in_raw = {irq_pin, cap_pin, tach_pin, estop_pin, 4'h0};
   assign inv_in = {{4{pol[PPM_POL_IRQ]}}, {4{pol[PPM_POL_CAP]}},
                    pol[PPM_POL_TACH], pol[PPM_POL_ESTOP], 4'h0};
   assign pol_out_raw = {cmp_periph, phase_periph};
   assign inv_out = {{4{pol[PPM_POL_CMP]}}, {6{pol[PPM_POL_PHASE]}}};

   ppm_polarity #(.WIDTH(14)) u_pol_in (
      .invert(inv_in),
      .from_pin(pol_in_raw),
      .to_periph(pol_in_cooked), // [RL15]
      .from_periph(14'h0),
      .to_pin()
   );
   ppm_polarity #(.WIDTH(10)) u_pol_out (
      .invert(inv_out),
      .from_pin(10'h0),
      .to_periph(),
      .from_periph(pol_out_raw),
      .to_pin(pol_out_cooked) // [RL15]
   );

   // ==========================================================
   // Pin drive and bus overlay
   logic [79:0] next_pin_out;
   logic [79:0] next_pin_oe;
   logic [15:0] ad_mux;

   always_comb begin
      next_pin_out = '0;
      next_pin_oe = '0;
      // Per-pin function choice; GP input leaves driver off [RL14]
      for (int i = 0; i < PPM_PINS; i++) begin
         unique case (fsel[i*2 +: 2])
            PPM_FN_GPIN: next_pin_oe[i] = 1'b0; // [RL1]
            PPM_FN_ALT1: begin
               next_pin_oe[i] = 1'b1;
               next_pin_out[i] = gpout[i];
            end
            PPM_FN_ALT2: begin
               next_pin_oe[i] = 1'b1;
               next_pin_out[i] = periph_out2[i]; // [RL14]
            end
            PPM_FN_ALT3: begin
               next_pin_oe[i] = 1'b1;
               next_pin_out[i] = periph_out3[i];
            end
         endcase
      end
      // Address phase carries address, data phase carries data
      ad_mux = ext_bus_addr_phase ? ext_bus_addr[15:0] : ext_bus_wdata;
      if (busctl[PPM_BUS_EN]) begin
         if (busctl[PPM_BUS_MODE]) begin
            // Muxed 16-bit: AD on p8/p9, high address on p7 [RL7]
            next_pin_out[PPM_P8_LSB +: 16] = ad_mux;
            next_pin_oe[PPM_P8_LSB +: 16] =
               {16{ext_bus_addr_phase | ext_bus_drive_data}};
            next_pin_out[PPM_P7_LSB +: 8] = ext_bus_addr[23:16];
            next_pin_oe[PPM_P7_LSB +: 8] = 8'hFF;
         end else begin
            // Plain 8-bit: data on p8, address on p7 and p9 [RL6]
            next_pin_out[PPM_P8_LSB +: 8] = ext_bus_wdata[7:0];
            next_pin_oe[PPM_P8_LSB +: 8] = {8{ext_bus_drive_data}};
            next_pin_out[PPM_P7_LSB +: 8] = ext_bus_addr[7:0];
            next_pin_oe[PPM_P7_LSB +: 8] = 8'hFF;
            next_pin_out[PPM_P9_LSB +: 8] = ext_bus_addr[15:8];
            next_pin_oe[PPM_P9_LSB +: 8] = 8'hFF;
         end
      end
   end

   // Registered pin drive and peripheral-side outputs
   // No pull control exists anywhere in this block [RL10]
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe <= '0;
         default_in <= '0;
         alt_in <= '0;
         ext_bus_rdata <= '0;
         ext_bus_low_write_strobe <= 1'b1;
         ext_bus_high_write_strobe <= 1'b1;
         ext_bus_address_latch_strobe <= 1'b0;
         irq_req <= '0;
         cap_in <= '0;
         tach_in <= 1'b0;
         estop_in <= 1'b0;
         cmp_pin <= '0;
         phase_pin <= '0;
         phy_reference_clock_out <= 1'b0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         default_in <= pin_sync & ~ain; // [RL3]
         alt_in <= pin_sync & ain; // [RL5]
         ext_bus_rdata <= busctl[PPM_BUS_MODE] ?
            pin_sync[PPM_P8_LSB +: 16] :
            {8'h00, pin_sync[PPM_P8_LSB +: 8]};
         // Strobe balls carry byte selects when chosen [RL9] [RL13]
         ext_bus_low_write_strobe <= busctl[PPM_BUS_BSEL] ?
            ext_bus_byte_low : ext_bus_wr_low;
         ext_bus_high_write_strobe <= busctl[PPM_BUS_BSEL] ?
            ext_bus_byte_high : ext_bus_wr_high;
         ext_bus_address_latch_strobe <=
            ext_bus_latch ^ busctl[PPM_BUS_ALEPOL]; // [RL8]
         {irq_req, cap_in, tach_in, estop_in} <= pol_in_cooked[13:4];
         {cmp_pin, phase_pin} <= pol_out_cooked;
         // Held low on variants lacking the network controller [RL12]
         phy_reference_clock_out <= HAS_ETH ? phy_clk_src : 1'b0;
      end
   end

   // ==========================================================
   // Checks
   property p_reset_hiz;
      @(posedge clock) disable iff (!rst_n)
      $rose(rst_n) |-> pin_oe == '0;
   endproperty
   a_reset_hiz: assert property (p_reset_hiz) // [RL1]
      else $error("pins driven right after reset");

   property p_gp_read;
      @(posedge clock) disable iff (!rst_n)
      (psel && !penable && !pwrite && paddr == PPM_A_PIN0)
         |=> prdata == $past(pin_sync[31:0]);
   endproperty
   a_gp_read: assert property (p_gp_read) // [RL4]
      else $error("pin level read wrong");

   property p_ready_one;
      @(posedge clock) disable iff (!rst_n)
      (psel && !penable) |=> pready ##1 !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) // Zero wait states: pready high for one cycle per transfer
      else $error("pready not a single cycle");

   property p_alt2_drive;
      @(posedge clock) disable iff (!rst_n)
      (fsel[1:0] == PPM_FN_ALT2 && !busctl[PPM_BUS_EN])
         |=> pin_oe[0] && pin_out[0] == $past(periph_out2[0]);
   endproperty
   a_alt2_drive: assert property (p_alt2_drive) // [RL14]
      else $error("alt output not driven");

   property p_gpin_hiz;
      @(posedge clock) disable iff (!rst_n)
      (fsel[1:0] == PPM_FN_GPIN) |=> !pin_oe[0];
   endproperty
   a_gpin_hiz: assert property (p_gpin_hiz) // [RL1]
      else $error("input pin driven");

   property p_bsel;
      @(posedge clock) disable iff (!rst_n)
      busctl[PPM_BUS_BSEL]
         |=> ext_bus_low_write_strobe == $past(ext_bus_byte_low);
   endproperty
   a_bsel: assert property (p_bsel) // [RL9]
      else $error("byte select not routed");

   property p_muxed_hi;
      @(posedge clock) disable iff (!rst_n)
      (busctl[PPM_BUS_EN] && busctl[PPM_BUS_MODE])
         |=> pin_out[PPM_P7_LSB +: 8] == $past(ext_bus_addr[23:16]);
   endproperty
   a_muxed_hi: assert property (p_muxed_hi) // [RL7]
      else $error("high address missing on port 7");

   property p_plain_addr;
      @(posedge clock) disable iff (!rst_n)
      (busctl[PPM_BUS_EN] && !busctl[PPM_BUS_MODE])
         |=> pin_oe[PPM_P9_LSB +: 8] == 8'hFF;
   endproperty
   a_plain_addr: assert property (p_plain_addr) // [RL6]
      else $error("address not driven on port 9");

   property p_pol_irq;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |=> irq_req == ($past(irq_pin) ^ {4{$past(pol[PPM_POL_IRQ])}});
   endproperty
   a_pol_irq: assert property (p_pol_irq) // [RL15]
      else $error("irq polarity wrong");

   property p_no_phy;
      @(posedge clock) disable iff (!rst_n)
      !HAS_ETH |-> !phy_reference_clock_out;
   endproperty
   a_no_phy: assert property (p_no_phy) // [RL12]
      else $error("phy clock on variant without it");

   property p_default_in;
      @(posedge clock) disable iff (!rst_n)
      !ain[0] |=> default_in[0] == $past(pin_sync[0]);
   endproperty
   a_default_in: assert property (p_default_in) // [RL3]
      else $error("default input not routed");
endmodule
`default_nettype wire

/* File: sim/ppm_pin_model.sv */
`default_nettype none
// ==========================================================
// Outside circuits wired to the port pins
module ppm_pin_model
   import ppm_pkg::*;
(
   input wire logic clock,
   input wire logic [ppm_pkg::PPM_PINS-1:0] pin_out,
   input wire logic [ppm_pkg::PPM_PINS-1:0] pin_oe,
   input wire logic [ppm_pkg::PPM_PINS-1:0] ext_val,
   input wire logic [ppm_pkg::PPM_PINS-1:0] ext_en,
   output logic [ppm_pkg::PPM_PINS-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Undriven lines wander, so a stale level never looks valid
   logic [ppm_pkg::PPM_PINS-1:0] float_q = '0;
   // ==========================================================
   // Floating pattern, flips every cycle
   always @(posedge clock) begin
      float_q <= ~float_q;
   end
   // ==========================================================
   // Wire level: device driver first, then outside drivers
   always_comb begin
      for (int i = 0; i < PPM_PINS; i++) begin
         if (pin_oe[i] === 1'b1) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else begin
            pin_in[i] = float_q[i]; // No pulls on the line
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
// ==========================================================
// Self-checking bench for the port pin function mux
`define CHK(NM, EXP, GOT) begin \
   n_tests++; \
   if ((GOT) !== (EXP)) begin \
      num_errors++; \
      $display("Error %s expected %0h seen %0h", NM, (EXP), (GOT)); \
   end \
end
module tb;
   import ppm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, g, seed = 32'h0001_62d9;
   logic [79:0] pin_in, pin_out, pin_oe, periph_out2, periph_out3;
   logic [79:0] default_in, alt_in, ext_val, ext_en, v, p2, p3;
   logic [23:0] ext_bus_addr;
   logic [15:0] ext_bus_wdata, ext_bus_rdata, e16;
   logic ext_bus_addr_phase, ext_bus_drive_data, ext_bus_wr_low;
   logic ext_bus_wr_high, ext_bus_byte_low, ext_bus_byte_high;
   logic ext_bus_latch, ext_bus_low_write_strobe;
   logic ext_bus_high_write_strobe, ext_bus_address_latch_strobe;
   logic [3:0] irq_pin, irq_req, cap_pin, cap_in, cmp_periph, cmp_pin;
   logic tach_pin, tach_in, estop_pin, estop_in;
   logic phy_clk_src, phy_reference_clock_out;
   logic [5:0] phase_periph, phase_pin;
   logic [33:0] exp_q[$]; // Notes: check-data, error, data
   logic [33:0] ent;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   ppm_mux i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
      .periph_out2, .periph_out3, .default_in, .alt_in, .ext_bus_addr,
      .ext_bus_wdata, .ext_bus_addr_phase, .ext_bus_drive_data,
      .ext_bus_rdata, .ext_bus_wr_low, .ext_bus_wr_high,
      .ext_bus_byte_low, .ext_bus_byte_high, .ext_bus_latch,
      .ext_bus_low_write_strobe, .ext_bus_high_write_strobe,
      .ext_bus_address_latch_strobe, .irq_pin, .irq_req, .cap_pin,
      .cap_in, .cmp_periph, .cmp_pin, .tach_pin, .tach_in, .estop_pin,
      .estop_in, .phase_periph, .phase_pin, .phy_clk_src,
      .phy_reference_clock_out);
   ppm_pin_model i_pins (.clock, .pin_out, .pin_oe, .ext_val, .ext_en,
      .pin_in);
   // ==========================================================
   // Clock, 50 ns period
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // LFSR words, 17 shifts apart
   function automatic logic [31:0] rnd();
      for (int i = 0; i < 17; i++) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      end
      return seed;
   endfunction
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      exp_q.push_back({2'b00, d});
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
         input logic er);
      exp_q.push_back({1'b1, er, e});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Oldest note per pready
   always @(posedge clock) begin
      if (pready === 1'b1) begin
         ent = exp_q.pop_front();
         `CHK("pslverr", ent[32], pslverr)
         if (ent[33]) `CHK("prdata", ent[31:0], prdata)
      end
   end
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("Error timeout expected done seen hang");
         wrap_up();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {periph_out2, periph_out3, ext_val, ext_bus_addr} = '0;
      {ext_bus_wdata, ext_bus_addr_phase, ext_bus_drive_data} = '0;
      {ext_bus_wr_low, ext_bus_wr_high, ext_bus_byte_low} = '0;
      {ext_bus_byte_high, ext_bus_latch, irq_pin, cap_pin} = '0;
      {cmp_periph, tach_pin, estop_pin, phase_periph, phy_clk_src} = '0;
      ext_en = '1;
      repeat (4) @(posedge clock);
      `CHK("pin_oe in reset", 80'h0, pin_oe)
      rst_n <= 1'b1;
      rd(PPM_A_FSEL0, 32'h0000_0000, 1'b0);
      rd(PPM_A_BUS, 32'h0000_0000, 1'b0);
      `CHK("pin_oe after reset", 80'h0, pin_oe)
      $display("Done reset state");
      // Pin levels and input routing
      g = rnd();
      v = {rnd(), rnd(), g[15:0]};
      ext_val <= v;
      repeat (5) @(posedge clock);
      rd(PPM_A_PIN0, v[31:0], 1'b0);
      rd(PPM_A_PIN1, v[63:32], 1'b0);
      rd(PPM_A_PIN2, {16'h0000, v[79:64]}, 1'b0);
      `CHK("default_in", v, default_in)
      `CHK("alt_in", 80'h0, alt_in)
      g = rnd();
      wr(PPM_A_AIN0, g);
      repeat (2) @(posedge clock);
      `CHK("alt_in", v[31:0] & g, alt_in[31:0])
      `CHK("default_in", v[31:0] & ~g, default_in[31:0])
      wr(PPM_A_AIN0, 32'h0000_0000);
      $display("Done input routing");
      // Every function code on pins 0..15
      p2 = {v[39:0], v[79:40]};
      p3 = ~v;
      periph_out2 <= p2;
      periph_out3 <= p3;
      for (int f = 0; f < 4; f++) begin
         g = rnd();
         wr(PPM_A_FSEL0, {16{2'(f)}});
         wr(PPM_A_GPOUT0, g);
         repeat (2) @(posedge clock);
         `CHK("pin_oe", {16{f != 0}}, pin_oe[15:0])
         e16 = (f == 1) ? g[15:0] : (f == 2) ? p2[15:0] : p3[15:0];
         if (f != 0) begin
            `CHK("pin_out", e16, pin_out[15:0])
            repeat (4) @(posedge clock);
            rd(PPM_A_PIN0, {v[31:16], e16}, 1'b0);
         end
      end
      // Unused pins parked as low outputs
      wr(PPM_A_FSEL0, 32'h5555_5555);
      wr(PPM_A_GPOUT0, 32'h0000_0000);
      repeat (2) @(posedge clock);
      `CHK("parked low", 16'h0000, pin_out[15:0])
      wr(PPM_A_FSEL0, 32'h0000_0000);
      $display("Done output choices");
      // Plain 8-bit bus
      g = rnd();
      ext_bus_addr <= g[23:0];
      ext_bus_wdata <= g[31:16];
      ext_bus_drive_data <= 1'b1;
      wr(PPM_A_BUS, 32'h0000_0001);
      repeat (2) @(posedge clock);
      `CHK("p7 addr", g[7:0], pin_out[63:56])
      `CHK("p9 addr", g[15:8], pin_out[79:72])
      `CHK("p8 data", g[23:16], pin_out[71:64])
      `CHK("bus oe", 24'hff_ffff, pin_oe[79:56])
      ext_bus_drive_data <= 1'b0;
      repeat (5) @(posedge clock);
      `CHK("p8 released", 8'h00, pin_oe[71:64])
      `CHK("rdata", v[71:64], ext_bus_rdata[7:0])
      // Muxed 16-bit bus
      wr(PPM_A_BUS, 32'h0000_0003);
      ext_bus_addr_phase <= 1'b1;
      repeat (2) @(posedge clock);
      `CHK("ad addr", g[15:0], pin_out[79:64])
      `CHK("p7 high addr", g[23:16], pin_out[63:56])
      ext_bus_addr_phase <= 1'b0;
      ext_bus_drive_data <= 1'b1;
      repeat (2) @(posedge clock);
      `CHK("ad data", g[31:16], pin_out[79:64])
      ext_bus_drive_data <= 1'b0;
      repeat (5) @(posedge clock);
      `CHK("ad read", v[79:64], ext_bus_rdata)
      $display("Done external bus");
      // Strobes and latch polarity
      for (int b = 0; b < 2; b++) begin
         g = rnd();
         {ext_bus_latch, ext_bus_byte_high, ext_bus_byte_low} <= g[4:2];
         {ext_bus_wr_high, ext_bus_wr_low} <= g[1:0];
         wr(PPM_A_BUS, b ? 32'h0000_000d : 32'h0000_0001);
         repeat (2) @(posedge clock);
         `CHK("wr lo", b ? g[2] : g[0], ext_bus_low_write_strobe)
         `CHK("wr hi", b ? g[3] : g[1], ext_bus_high_write_strobe)
         `CHK("latch", g[4] ^ 1'(b), ext_bus_address_latch_strobe)
      end
      // Polarity, both settings
      for (int b = 0; b < 2; b++) begin
         g = rnd();
         {irq_pin, cap_pin, cmp_periph} <= g[11:0];
         {phase_periph, estop_pin, tach_pin} <= g[19:12];
         phy_clk_src <= g[20];
         wr(PPM_A_POL, b ? 32'h0000_003f : 32'h0000_0000);
         repeat (2) @(posedge clock);
         `CHK("irq", g[11:8] ^ {4{1'(b)}}, irq_req)
         `CHK("cap", g[7:4] ^ {4{1'(b)}}, cap_in)
         `CHK("cmp", g[3:0] ^ {4{1'(b)}}, cmp_pin)
         `CHK("tach", g[12] ^ 1'(b), tach_in)
         `CHK("estop", g[13] ^ 1'(b), estop_in)
         `CHK("phase", g[19:14] ^ {6{1'(b)}}, phase_pin)
         `CHK("phy clock", g[20], phy_reference_clock_out)
      end
      rd(PPM_A_POL, 32'h0000_003f, 1'b0);
      rd(12'h05c, 32'h0000_0000, 1'b1);
      repeat (2) @(posedge clock);
      $display("Done polarity and strobes");
      wrap_up();
   end
endmodule
`default_nettype wire
